// ### common/serial_setup_pkg.sv
// Package: register map, field layout, codes and decode helpers for the port setup bank
package serial_setup_pkg;

  // AXI4-Lite byte offsets
  localparam int AXI_AW = 6;
  localparam logic [AXI_AW-1:0] OFS_BUF_BASE = 6'h00;
  localparam logic [AXI_AW-1:0] OFS_TIMING = 6'h04;
  localparam logic [AXI_AW-1:0] OFS_LINE = 6'h08;
  localparam logic [AXI_AW-1:0] OFS_HANDSHAKE = 6'h0c;
  localparam logic [AXI_AW-1:0] OFS_IRQ_STATUS = 6'h10;
  localparam logic [AXI_AW-1:0] OFS_IRQ_MASK = 6'h14;
  localparam logic [AXI_AW-1:0] OFS_ACT_TIMING = 6'h18;
  localparam logic [AXI_AW-1:0] OFS_ACT_LINE = 6'h1c;
  localparam logic [AXI_AW-1:0] OFS_ACT_BASE = 6'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Handshake word codes
  localparam logic [15:0] HS_REQUEST = 16'h0500;
  localparam logic [15:0] HS_ACCEPTED = 16'h0a00;
  localparam logic [15:0] HS_ERROR = 16'h0e00;

  // Timing/protocol word layout
  localparam int TP_RTS_ON_LSB = 12;
  localparam int TP_TMO_LSB = 8;
  localparam int TP_PROTO_LSB = 3;
  localparam int TP_RTS_OFF_LSB = 0;
  localparam int TP_ZERO_HI = 15;
  localparam int TP_ZERO_MID = 11;

  // Line-parameter word layout
  localparam int LP_PARITY_LSB = 14;
  localparam int LP_STOP_BIT = 13;
  localparam int LP_DATA_BIT = 12;
  localparam int LP_ECHO_BIT = 11;
  localparam int LP_BAUD_LSB = 8;
  localparam int LP_FMT_BIT = 7;
  localparam int LP_STATION_LSB = 0;
  localparam int LP_FLOW_LSB = 0;
  localparam int LP_FLOW_PREFIX_LSB = 2;

  // Protocol, parity and flow codes
  localparam logic [4:0] PROTO_PROG = 5'h10;
  localparam logic [4:0] PROTO_NATIVE = 5'h08;
  localparam logic [4:0] PROTO_MODBUS = 5'h04;
  localparam logic [4:0] PROTO_RAW = 5'h02;
  localparam logic [1:0] PAR_RESERVED = 2'h1;
  localparam logic [5:0] FLOW_PREFIX = 6'h1c;
  localparam logic [7:0] STATION_MASK_7 = 8'h7f;
  localparam logic [7:0] STATION_MIN = 8'h01;
  localparam logic [7:0] STATION_MAX_VENDOR = 8'h5a;
  localparam logic [7:0] STATION_MAX_MODBUS = 8'hf7;
  localparam logic [15:0] PCT_BASE = 16'h0064;

  // Interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_ACCEPT = 0;
  localparam int IRQ_REJECT = 1;

  // Reset setup: auto protocol, x1 timeout, odd parity, 19200, station 1
  localparam logic [15:0] RST_TIMING = 16'h0000;
  localparam logic [15:0] RST_LINE = 16'h8601;

  typedef struct packed {
    logic [15:0] timing;
    logic [15:0] line;
    logic [15:0] base;
  } setup_words_s;

  typedef struct packed {
    logic [4:0] proto;
    logic [1:0] parity;
    logic two_stop;
    logic seven_bits;
    logic echo;
    logic ascii_fmt;
    logic [1:0] flow;
    logic [7:0] station;
    logic [15:0] baud;
    logic [15:0] rts_on_ms;
    logic [15:0] rts_off_ms;
    logic [15:0] timeout_pct;
    logic [15:0] timeout_add_ms;
    logic [15:0] buf_base;
  } port_cfg_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01
  } hs_state_e;

  // Three-bit delay code to milliseconds
  function automatic logic [15:0] delay_ms(input logic [2:0] code);
    case (code)
      3'h0: delay_ms = 16'h0000;
      3'h1: delay_ms = 16'h0002;
      3'h2: delay_ms = 16'h0005;
      3'h3: delay_ms = 16'h000a;
      3'h4: delay_ms = 16'h0014;
      3'h5: delay_ms = 16'h0032;
      3'h6: delay_ms = 16'h0064;
      default: delay_ms = 16'h01f4;
    endcase
  endfunction

  // Timeout code to percent of base
  function automatic logic [15:0] timeout_pct(input logic [2:0] code);
    case (code)
      3'h0: timeout_pct = 16'h0064;
      3'h1: timeout_pct = 16'h0078;
      3'h2: timeout_pct = 16'h0096;
      3'h3: timeout_pct = 16'h00c8;
      3'h4: timeout_pct = 16'h01f4;
      3'h5: timeout_pct = 16'h03e8;
      3'h6: timeout_pct = 16'h07d0;
      default: timeout_pct = 16'h1388;
    endcase
  endfunction

  // Baud code to bit rate
  function automatic logic [15:0] baud_rate(input logic [2:0] code);
    case (code)
      3'h0: baud_rate = 16'h012c;
      3'h1: baud_rate = 16'h0258;
      3'h2: baud_rate = 16'h04b0;
      3'h3: baud_rate = 16'h0960;
      3'h4: baud_rate = 16'h12c0;
      3'h5: baud_rate = 16'h2580;
      3'h6: baud_rate = 16'h4b00;
      default: baud_rate = 16'h9600;
    endcase
  endfunction

  // Setup words to decoded port settings; layout chosen by protocol
  function automatic port_cfg_s decode_cfg(input setup_words_s w);
    port_cfg_s c;
    logic raw;
    c = '0;
    c.proto = w.timing[TP_PROTO_LSB +: 5];
    raw = (c.proto == PROTO_RAW);
    c.parity = w.line[LP_PARITY_LSB +: 2];
    c.two_stop = w.line[LP_STOP_BIT];
    c.seven_bits = raw & w.line[LP_DATA_BIT];
    c.echo = w.line[LP_ECHO_BIT];
    c.ascii_fmt = (c.proto == PROTO_NATIVE) & w.line[LP_FMT_BIT];
    c.station = w.line[LP_STATION_LSB +: 8];
    if (c.proto != PROTO_MODBUS)
      c.station = c.station & STATION_MASK_7;
    if (raw)
      c.station = '0;
    c.flow = raw ? w.line[LP_FLOW_LSB +: 2] : 2'h0;
    c.baud = baud_rate(w.line[LP_BAUD_LSB +: 3]);
    c.rts_on_ms = delay_ms(w.timing[TP_RTS_ON_LSB +: 3]);
    c.rts_off_ms = delay_ms(w.timing[TP_RTS_OFF_LSB +: 3]);
    c.timeout_pct = raw ? PCT_BASE : timeout_pct(w.timing[TP_TMO_LSB +: 3]);
    c.timeout_add_ms = raw ? delay_ms(w.timing[TP_TMO_LSB +: 3]) : 16'h0000;
    c.buf_base = raw ? w.base : 16'h0000;
    return c;
  endfunction

endpackage

// ### src/setup_word_checker.sv
// Setup word validity check with registered result
`timescale 1ns/100ps
module setup_word_checker (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input serial_setup_pkg::setup_words_s i_words,
  output serial_setup_pkg::setup_words_s o_words,
  output logic o_ok
);
  import serial_setup_pkg::*;

  port_cfg_s cfg;
  logic framed;
  logic addr_ok;
  logic ok_next;

  // Field checks for the layout picked by the protocol code
  always_comb
  begin
    cfg = decode_cfg(i_words);
    framed = (cfg.proto == PROTO_PROG) || (cfg.proto == PROTO_NATIVE) || (cfg.proto == PROTO_MODBUS);
    addr_ok = (cfg.station >= STATION_MIN) &&
      (cfg.station <= ((cfg.proto == PROTO_MODBUS) ? STATION_MAX_MODBUS : STATION_MAX_VENDOR));
    ok_next = !i_words.timing[TP_ZERO_HI] && !i_words.timing[TP_ZERO_MID] && (cfg.parity != PAR_RESERVED);
    if (framed)
      ok_next = ok_next && addr_ok && !i_words.line[LP_DATA_BIT];
    else if (cfg.proto == PROTO_RAW)
      ok_next = ok_next && (i_words.line[LP_FLOW_PREFIX_LSB +: 6] == FLOW_PREFIX);
    else
      ok_next = 1'b0;
  end

  // Words and verdict move together so the verdict always matches its words
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_words <= '0;
      o_ok <= 1'b0;
    end
    else
    begin
      o_words <= i_words;
      o_ok <= ok_next;
    end
  end

endmodule // setup_word_checker

// ### src/serial_port_setup.sv
// Serial port setup bank with accept/reject handshake behind AXI4-Lite
`timescale 1ns/100ps
module serial_port_setup (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [serial_setup_pkg::AXI_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [serial_setup_pkg::AXI_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_irq,
  output serial_setup_pkg::port_cfg_s o_port_cfg
);
  import serial_setup_pkg::*;

  // Decoded reset setup, fixed at elaboration so the reset branch loads a constant
  localparam port_cfg_s RST_CFG = decode_cfg(setup_words_s'({RST_TIMING, RST_LINE, 16'h0000}));

  logic [AXI_AW-1:0] aw_addr_reg;
  logic aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_full_reg;
  logic wr_fire;
  logic ar_fire;
  logic wr_mapped;
  logic [15:0] buf_base_reg;
  logic [15:0] timing_reg;
  logic [15:0] line_reg;
  logic [15:0] hs_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [15:0] act_timing_reg;
  logic [15:0] act_line_reg;
  logic [15:0] act_base_reg;
  hs_state_e state_reg;
  hs_state_e state_next;
  setup_words_s chk_words;
  logic chk_ok;
  logic [31:0] rd_next;
  logic rd_mapped;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign wr_fire = aw_full_reg && w_full_reg && !o_bvalid;
  assign ar_fire = i_arvalid && o_arready;

  // Write address channel holding register
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_addr_reg <= '0;
      aw_full_reg <= 1'b0;
      o_awready <= 1'b1;
    end
    else if (i_awvalid && o_awready)
    begin
      aw_addr_reg <= i_awaddr;
      aw_full_reg <= 1'b1;
      o_awready <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_full_reg <= 1'b0;
      o_awready <= 1'b1;
    end
  end

  // Write data channel holding register
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      w_data_reg <= '0;
      w_strb_reg <= '0;
      w_full_reg <= 1'b0;
      o_wready <= 1'b1;
    end
    else if (i_wvalid && o_wready)
    begin
      w_data_reg <= i_wdata;
      w_strb_reg <= i_wstrb;
      w_full_reg <= 1'b1;
      o_wready <= 1'b0;
    end
    else if (wr_fire)
    begin
      w_full_reg <= 1'b0;
      o_wready <= 1'b1;
    end
  end

  // Write address decode
  always_comb
  begin
    case (aw_addr_reg)
      OFS_BUF_BASE, OFS_TIMING, OFS_LINE, OFS_HANDSHAKE, OFS_IRQ_STATUS, OFS_IRQ_MASK,
      OFS_ACT_TIMING, OFS_ACT_LINE, OFS_ACT_BASE: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      o_bvalid <= 1'b1;
      o_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  // Setup words written by software
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      buf_base_reg <= '0;
      timing_reg <= RST_TIMING;
      line_reg <= RST_LINE;
      irq_mask_reg <= '0;
    end
    else if (wr_fire)
    begin
      if (aw_addr_reg == OFS_BUF_BASE)
        buf_base_reg <= merge16(buf_base_reg, w_data_reg, w_strb_reg);
      if (aw_addr_reg == OFS_TIMING)
        timing_reg <= merge16(timing_reg, w_data_reg, w_strb_reg);
      if (aw_addr_reg == OFS_LINE)
        line_reg <= merge16(line_reg, w_data_reg, w_strb_reg);
      if (aw_addr_reg == OFS_IRQ_MASK && w_strb_reg[0])
        irq_mask_reg <= w_data_reg[IRQ_W-1:0];
    end
  end

  // Handshake word; the device result wins over a bus write in the same cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      hs_reg <= '0;
    else if (state_reg == ST_CHECK)
      hs_reg <= chk_ok ? HS_ACCEPTED : HS_ERROR;
    else if (wr_fire && aw_addr_reg == OFS_HANDSHAKE)
      hs_reg <= merge16(hs_reg, w_data_reg, w_strb_reg);
  end

  // Validation of the current setup words
  setup_word_checker u_checker (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_words({timing_reg, line_reg, buf_base_reg}),
    .o_words(chk_words),
    .o_ok(chk_ok)
  );

  // Handshake sequencer
  always_comb
  begin
    case (state_reg)
      ST_IDLE: state_next = (hs_reg == HS_REQUEST) ? ST_CHECK : ST_IDLE;
      ST_CHECK: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Active configuration, loaded only on acceptance
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      act_timing_reg <= RST_TIMING;
      act_line_reg <= RST_LINE;
      act_base_reg <= '0;
      o_port_cfg <= RST_CFG;
    end
    else if (state_reg == ST_CHECK && chk_ok)
    begin
      act_timing_reg <= chk_words.timing;
      act_line_reg <= chk_words.line;
      act_base_reg <= chk_words.base;
      o_port_cfg <= decode_cfg(chk_words);
    end
  end

  // Event status, write one to clear; a new event wins over its clear
  always_comb
  begin
    irq_set = '0;
    irq_set[IRQ_ACCEPT] = (state_reg == ST_CHECK) && chk_ok;
    irq_set[IRQ_REJECT] = (state_reg == ST_CHECK) && !chk_ok;
    irq_clr = (wr_fire && aw_addr_reg == OFS_IRQ_STATUS && w_strb_reg[0]) ? w_data_reg[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq_stat_reg <= '0;
    else
      irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);
  end

  // Level interrupt from unmasked status
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_stat_reg & irq_mask_reg);
  end

  // Read data mux
  always_comb
  begin
    rd_next = '0;
    rd_mapped = 1'b1;
    case (i_araddr)
      OFS_BUF_BASE: rd_next[15:0] = buf_base_reg;
      OFS_TIMING: rd_next[15:0] = timing_reg;
      OFS_LINE: rd_next[15:0] = line_reg;
      OFS_HANDSHAKE: rd_next[15:0] = hs_reg;
      OFS_IRQ_STATUS: rd_next[IRQ_W-1:0] = irq_stat_reg;
      OFS_IRQ_MASK: rd_next[IRQ_W-1:0] = irq_mask_reg;
      OFS_ACT_TIMING: rd_next[15:0] = act_timing_reg;
      OFS_ACT_LINE: rd_next[15:0] = act_line_reg;
      OFS_ACT_BASE: rd_next[15:0] = act_base_reg;
      default: rd_mapped = 1'b0;
    endcase
  end

  // Read channel
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_next;
      o_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Checks on the handshake and the applied settings
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  req_to_check_a: assert property ((state_reg == ST_IDLE && hs_reg == HS_REQUEST) |=>
    state_reg == ST_CHECK ##1 hs_reg != HS_REQUEST)
    else $error("request code not answered");
  accept_code_a: assert property ((state_reg == ST_CHECK && chk_ok) |=> hs_reg == HS_ACCEPTED)
    else $error("accepted code missing");
  error_code_a: assert property ((state_reg == ST_CHECK && !chk_ok) |=> hs_reg == HS_ERROR)
    else $error("error code missing");
  keep_config_a: assert property ((state_reg == ST_CHECK && !chk_ok) |=> $stable(o_port_cfg))
    else $error("rejected setup changed active settings");
  apply_config_a: assert property ((state_reg == ST_CHECK && chk_ok) |=>
    o_port_cfg == decode_cfg($past(chk_words)) && o_port_cfg.proto == $past(chk_words.timing[TP_PROTO_LSB +: 5]))
    else $error("accepted setup not applied");
  rts_map_a: assert property ((state_reg == ST_CHECK && chk_ok && chk_words.timing[TP_RTS_ON_LSB +: 3] == 3'h7)
    |=> o_port_cfg.rts_on_ms == 16'h01f4)
    else $error("rts delay mapping wrong");
  raw_timeout_a: assert property ((state_reg == ST_CHECK && chk_ok && chk_words.timing[TP_PROTO_LSB +: 5] == PROTO_RAW)
    |=> o_port_cfg.timeout_pct == PCT_BASE &&
    o_port_cfg.timeout_add_ms == delay_ms($past(chk_words.timing[TP_TMO_LSB +: 3])))
    else $error("raw timeout not additive");
  parity_ok_a: assert property ((state_reg == ST_CHECK && chk_ok) |->
    chk_words.line[LP_PARITY_LSB +: 2] != PAR_RESERVED)
    else $error("reserved parity accepted");
  baud_map_a: assert property ((state_reg == ST_CHECK && chk_ok && chk_words.line[LP_BAUD_LSB +: 3] == 3'h0)
    |=> o_port_cfg.baud == 16'h012c && o_port_cfg.echo == $past(chk_words.line[LP_ECHO_BIT]))
    else $error("baud mapping wrong");
  station_rng_a: assert property ((state_reg == ST_CHECK && chk_ok &&
    chk_words.timing[TP_PROTO_LSB +: 5] == PROTO_MODBUS) |-> chk_words.line[LP_STATION_LSB +: 8] >= STATION_MIN &&
    chk_words.line[LP_STATION_LSB +: 8] <= STATION_MAX_MODBUS)
    else $error("station out of range accepted");
  raw_flow_a: assert property ((state_reg == ST_CHECK && chk_ok &&
    chk_words.timing[TP_PROTO_LSB +: 5] == PROTO_RAW)
    |-> chk_words.line[LP_FLOW_PREFIX_LSB +: 6] == FLOW_PREFIX)
    else $error("bad flow code accepted");
  irq_level_a: assert property ((state_reg == ST_CHECK) |=> ##1 o_irq == |(irq_mask_reg & $past(irq_stat_reg | irq_set)))
    else $error("interrupt level wrong");

  accept_seen_c: cover property ((state_reg == ST_CHECK && chk_ok) ##1 hs_reg == HS_ACCEPTED);
  reject_seen_c: cover property ((state_reg == ST_CHECK && !chk_ok) ##1 hs_reg == HS_ERROR);
  raw_accept_c: cover property (state_reg == ST_CHECK && chk_ok &&
    chk_words.timing[TP_PROTO_LSB +: 5] == PROTO_RAW);

endmodule // serial_port_setup

// ### sim/test_serial_port_setup_handshake.sv
// Testbench for the serial port setup bank and its handshake
`timescale 1ns/100ps
module test_serial_port_setup_handshake;
  import serial_setup_pkg::*;
  logic clk;
  logic rst_n;
  logic [5:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [5:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic irq;
  port_cfg_s cfg;
  logic [15:0] rd;
  int n_fail;
  int cmp_count;

  // Device under test, both byte lanes always written
  serial_port_setup i_dut (
    .i_core_clk(clk), .i_rst_n(rst_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'h3), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_irq(irq), .o_port_cfg(cfg)
  );

  // Verdict and end of run
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A wait ran out of cycles
  task automatic expire();
    check(16'h0000, 16'h0001);
    print_verdict();
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] er);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (40)
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        check(16'(bresp), 16'(er));
        bready <= 1'b0;
        @(posedge clk);
        return;
      end
    end
    expire();
  endtask

  // Bus read
  task automatic axi_rd(input logic [5:0] a, output logic [15:0] d, input logic [1:0] er);
    d = 16'hffff;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (40)
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata[15:0];
        check(16'(rresp), 16'(er));
        rready <= 1'b0;
        @(posedge clk);
        return;
      end
    end
    expire();
  endtask

  // Load setup words, request, poll for the result code
  task automatic setup(input logic [15:0] t, input logic [15:0] l, input logic [15:0] b, input logic [15:0] res);
    axi_wr(OFS_BUF_BASE, b, RESP_OKAY);
    axi_wr(OFS_TIMING, t, RESP_OKAY);
    axi_wr(OFS_LINE, l, RESP_OKAY);
    axi_wr(OFS_HANDSHAKE, HS_REQUEST, RESP_OKAY);
    rd = HS_REQUEST;
    for (int i = 0; i < 10 && rd === HS_REQUEST; i++)
      axi_rd(OFS_HANDSHAKE, rd, RESP_OKAY);
    if (rd === HS_REQUEST)
      expire();
    check(rd, res);
  endtask

  // Values after reset
  task automatic t_reset();
    axi_rd(OFS_TIMING, rd, RESP_OKAY);
    check(rd, 16'h0000);
    axi_rd(OFS_LINE, rd, RESP_OKAY);
    check(rd, 16'h8601);
    axi_rd(OFS_HANDSHAKE, rd, RESP_OKAY);
    check(rd, 16'h0000);
    axi_rd(OFS_IRQ_STATUS, rd, RESP_OKAY);
    check(rd, 16'h0000);
    check(cfg.baud, 16'h4b00);
    check(16'(irq), 16'h0000);
  endtask

  // Framed protocol accepted, fields decoded, interrupt raised and cleared
  task automatic t_modbus();
    axi_wr(OFS_IRQ_MASK, 16'h0003, RESP_OKAY);
    setup(16'h3022, 16'h8617, 16'h0000, HS_ACCEPTED);
    check(16'(cfg.proto), 16'h0004);
    check(cfg.rts_on_ms, 16'h000a);
    check(cfg.rts_off_ms, 16'h0005);
    check(cfg.timeout_pct, 16'h0064);
    check(16'(cfg.parity), 16'h0002);
    check(cfg.baud, 16'h4b00);
    check(16'(cfg.station), 16'h0017);
    check(16'(irq), 16'h0001);
    axi_rd(OFS_IRQ_STATUS, rd, RESP_OKAY);
    check(rd, 16'h0001);
    axi_wr(OFS_IRQ_STATUS, 16'h0001, RESP_OKAY);
    check(16'(irq), 16'h0000);
    axi_rd(OFS_ACT_TIMING, rd, RESP_OKAY);
    check(rd, 16'h3022);
  endtask

  // Raw-character layout, every flow code
  task automatic t_raw();
    setup(16'h7710, 16'hd873, 16'h1234, HS_ACCEPTED);
    check(cfg.timeout_add_ms, 16'h01f4);
    check(cfg.timeout_pct, 16'h0064);
    check(cfg.rts_on_ms, 16'h01f4);
    check(16'(cfg.parity), 16'h0003);
    check(16'(cfg.seven_bits), 16'h0001);
    check(16'(cfg.echo), 16'h0001);
    check(cfg.baud, 16'h012c);
    check(cfg.buf_base, 16'h1234);
    axi_rd(OFS_ACT_BASE, rd, RESP_OKAY);
    check(rd, 16'h1234);
    for (int f = 0; f < 4; f++)
    begin
      setup(16'h0110, 16'h2570 | 16'(f), 16'h0040, HS_ACCEPTED);
      check(16'(cfg.flow), 16'(f));
      check(16'(cfg.two_stop), 16'h0001);
      check(16'(cfg.seven_bits), 16'h0000);
      check(cfg.timeout_add_ms, 16'h0002);
      check(cfg.baud, 16'h2580);
    end
  endtask

  // Accept and reject table; a reject keeps the active setup
  task automatic t_table();
    logic [15:0] tw [10] = '{16'h0020, 16'h0020, 16'h0040, 16'h0008, 16'h0020,
                             16'h8020, 16'h0010, 16'h0020, 16'h0080, 16'h0040};
    logic [15:0] lw [10] = '{16'h86f7, 16'h8600, 16'h865b, 16'h8601, 16'h4601,
                             16'h8601, 16'h8674, 16'h9601, 16'h8601, 16'h86da};
    logic ok [10] = '{1, 0, 0, 0, 0, 0, 0, 0, 1, 1};
    logic [4:0] lastp;
    lastp = PROTO_RAW;
    axi_wr(OFS_IRQ_MASK, 16'h0001, RESP_OKAY);
    for (int i = 0; i < 10; i++)
    begin
      axi_wr(OFS_IRQ_STATUS, 16'h0003, RESP_OKAY);
      setup(tw[i], lw[i], 16'h0000, ok[i] ? HS_ACCEPTED : HS_ERROR);
      if (ok[i])
        lastp = tw[i][7:3];
      check(16'(cfg.proto), 16'(lastp));
      axi_rd(OFS_IRQ_STATUS, rd, RESP_OKAY);
      check(rd, ok[i] ? 16'h0001 : 16'h0002);
      check(16'(irq), 16'(ok[i]));
    end
    check(16'(cfg.station), 16'h005a);
    check(16'(cfg.ascii_fmt), 16'h0001);
  endtask

  // Unmapped and read-only places
  task automatic t_bus();
    axi_wr(6'h3c, 16'h5555, RESP_SLVERR);
    axi_rd(6'h3c, rd, RESP_SLVERR);
    check(rd, 16'h0000);
    axi_rd(OFS_IRQ_MASK, rd, RESP_OKAY);
    check(rd, 16'h0001);
    axi_rd(OFS_BUF_BASE, rd, RESP_OKAY);
    check(rd, 16'h0000);
    axi_wr(OFS_ACT_LINE, 16'h0000, RESP_OKAY);
    axi_rd(OFS_ACT_LINE, rd, RESP_OKAY);
    check(rd, 16'h86da);
  endtask

  // Clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever
      #20 clk = ~clk;
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    awaddr = 6'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 6'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_modbus();
    t_raw();
    t_table();
    t_bus();
    print_verdict();
  end
endmodule // test_serial_port_setup_handshake
